// *** dhp_chan.sv ***
// Register block of one channel: holding registers, port control and ready outputs.
`timescale 1ns/1ps
`include "dhp_map.svh"
module dhp_chan (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Access from the host port
	input wire logic rd_pulse,
	input wire logic wr_pulse,
	input wire dhp_pkg::dhp_addr_type addr,
	input wire dhp_pkg::dhp_byte_type wdata,
	output dhp_pkg::dhp_byte_type rdata,
	// Serial side of the channel
	output dhp_pkg::dhp_byte_type tx_data,
	output logic tx_valid,
	input wire logic tx_take,
	input wire dhp_pkg::dhp_byte_type rx_data,
	input wire logic rx_push,
	input wire logic irq_req,
	// Pins
	output logic irq_out,
	output logic irq_oe,
	output logic user_output_n,
	output logic tx_ready_n,
	output logic rx_ready_n
);
	import dhp_pkg::*;

	// ****************************************
	// Register state
	// ****************************************
	dhp_byte_type regs_q [8];
	dhp_byte_type regs_d [8];
	dhp_byte_type tx_hold_q, tx_hold_d, rx_hold_q, rx_hold_d, pcr_q, pcr_d, rdata_q, rdata_d;
	logic tx_full_q, tx_full_d, rx_full_q, rx_full_d;
	logic irq_out_q, irq_out_d, irq_oe_q, irq_oe_d, user_n_q, user_n_d;
	logic tx_rdy_n_q, tx_rdy_n_d, rx_rdy_n_q, rx_rdy_n_d;
	logic hold_wr, hold_rd;

	always_comb begin
		hold_wr = wr_pulse && (addr == `DHP_ADDR_HOLD);
		hold_rd = rd_pulse && (addr == `DHP_ADDR_HOLD);
		regs_d = regs_q;
		tx_hold_d = tx_hold_q;
		pcr_d = pcr_q;
		rdata_d = rdata_q;
		rx_hold_d = rx_push ? rx_data : rx_hold_q;
		// A new byte wins over the consuming access in the same cycle, so nothing is lost.
		tx_full_d = hold_wr ? 1'b1 : (tx_take ? 1'b0 : tx_full_q);
		rx_full_d = rx_push ? 1'b1 : (hold_rd ? 1'b0 : rx_full_q);
		if (wr_pulse) begin
			case (addr)
				`DHP_ADDR_HOLD: tx_hold_d = wdata;
				`DHP_ADDR_PCR: pcr_d = wdata;
				`DHP_ADDR_LINE: pcr_d = pcr_q;
				default: regs_d[addr] = wdata;
			endcase
		end
		if (rd_pulse) begin
			case (addr)
				`DHP_ADDR_HOLD: rdata_d = rx_hold_q;
				`DHP_ADDR_PCR: rdata_d = pcr_q;
				`DHP_ADDR_LINE: begin
					rdata_d = `DHP_BYTE_RESET;
					rdata_d[`DHP_LINE_RXDATA_BIT] = rx_full_q;
					rdata_d[`DHP_LINE_THR_EMPTY_BIT] = !tx_full_q;
					rdata_d[`DHP_LINE_TX_EMPTY_BIT] = !tx_full_q;
				end
				default: rdata_d = regs_q[addr];
			endcase
		end
		// Interrupt pin is driven only while the control bit is one; user output is its complement.
		irq_oe_d = pcr_d[`DHP_PCR_OUT2_BIT];
		user_n_d = !pcr_d[`DHP_PCR_OUT2_BIT];
		irq_out_d = irq_req;
		// Single-byte mode encoding: ready while the holding register can take or give a byte.
		tx_rdy_n_d = tx_full_d;
		rx_rdy_n_d = !rx_full_d;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				regs_q[i] <= `DHP_BYTE_RESET;
			end
			tx_hold_q <= `DHP_BYTE_RESET;
			rx_hold_q <= `DHP_BYTE_RESET;
			pcr_q <= `DHP_PCR_RESET;
			rdata_q <= `DHP_BYTE_RESET;
			tx_full_q <= 1'b0;
			rx_full_q <= 1'b0;
			irq_out_q <= 1'b0;
			irq_oe_q <= 1'b0;
			user_n_q <= 1'b1;
			tx_rdy_n_q <= 1'b0;
			rx_rdy_n_q <= 1'b1;
		end else begin
			regs_q <= regs_d;
			tx_hold_q <= tx_hold_d;
			rx_hold_q <= rx_hold_d;
			pcr_q <= pcr_d;
			rdata_q <= rdata_d;
			tx_full_q <= tx_full_d;
			rx_full_q <= rx_full_d;
			irq_out_q <= irq_out_d;
			irq_oe_q <= irq_oe_d;
			user_n_q <= user_n_d;
			tx_rdy_n_q <= tx_rdy_n_d;
			rx_rdy_n_q <= rx_rdy_n_d;
		end
	end

	assign rdata = rdata_q;
	assign tx_data = tx_hold_q;
	assign tx_valid = tx_full_q;
	assign irq_out = irq_out_q;
	assign irq_oe = irq_oe_q;
	assign user_output_n = user_n_q;
	assign tx_ready_n = tx_rdy_n_q;
	assign rx_ready_n = rx_rdy_n_q;

	// ****************************************
	// Assertions
	// ****************************************
	AST_PCR_ON: assert property (@(posedge clk) disable iff (!rst_n)
		wr_pulse && addr == `DHP_ADDR_PCR && wdata[`DHP_PCR_OUT2_BIT] |=> irq_oe && !user_output_n)
		else $error("Control bit set but interrupt pin not driven.");
	AST_PCR_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		!pcr_q[`DHP_PCR_OUT2_BIT] |-> !irq_oe && user_output_n)
		else $error("Control bit clear but interrupt pin driven.");
	AST_TX_READY: assert property (@(posedge clk) disable iff (!rst_n)
		hold_wr |=> tx_ready_n ##1 (tx_ready_n || $past(tx_take)))
		else $error("Transmit ready still shown after a byte was written.");
	AST_RX_READY: assert property (@(posedge clk) disable iff (!rst_n)
		rx_push |=> !rx_ready_n)
		else $error("Receive ready not shown after a byte arrived.");
	AST_RX_DRAIN: assert property (@(posedge clk) disable iff (!rst_n)
		hold_rd && !rx_push |=> rx_ready_n)
		else $error("Receive ready still shown after the holding register was read.");
	COV_PCR_ON: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq_oe));
	COV_RX_READ: cover property (@(posedge clk) disable iff (!rst_n) rx_push ##[1:20] hold_rd);
endmodule : dhp_chan

// *** dhp_host_model.sv ***
// Host processor model that runs read and write cycles on the parallel port.
`timescale 1ns/1ps
module dhp_host_model (
	// Clock
	input wire logic ref_clk,
	// Host bus
	output dhp_pkg::dhp_addr_type addr,
	output dhp_pkg::dhp_byte_type data_in,
	input wire dhp_pkg::dhp_byte_type data_out,
	input wire logic data_oe,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic chan_a_select_n,
	output logic chan_b_select_n
);
	import dhp_pkg::*;
	// A released bus shows the inverse of its last value, so a missing drive never reads as a match.
	dhp_byte_type last_q;
	initial begin
		addr = 3'h0;
		data_in = 8'hFF;
		last_q = 8'h00;
		read_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		chan_a_select_n = 1'b1;
		chan_b_select_n = 1'b1;
	end
	// ****************************************
	// Bus cycles
	// ****************************************
	task automatic set_select(input logic chan, input logic both);
		chan_a_select_n = chan & ~both;
		chan_b_select_n = ~chan & ~both;
	endtask : set_select
	task automatic release_bus;
		chan_a_select_n = 1'b1;
		chan_b_select_n = 1'b1;
		data_in = ~last_q;
	endtask : release_bus
	task automatic bus_write(input logic chan, input logic both, input dhp_addr_type a, input dhp_byte_type d);
		@(negedge ref_clk);
		set_select(chan, both);
		addr = a;
		data_in = d;
		write_strobe_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		write_strobe_n = 1'b1;
		last_q = d;
		release_bus();
		repeat (4) @(negedge ref_clk);
	endtask : bus_write
	task automatic bus_read(input logic chan, input dhp_addr_type a, output dhp_byte_type d, output logic ok);
		@(negedge ref_clk);
		set_select(chan, 1'b0);
		addr = a;
		read_strobe_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		ok = data_oe;
		d = data_oe ? data_out : ~last_q;
		last_q = d;
		read_strobe_n = 1'b1;
		release_bus();
		repeat (3) @(negedge ref_clk);
	endtask : bus_read
endmodule : dhp_host_model

// *** dhp_map.svh ***
// Register offsets, field positions and reset values of the dual-channel host port.
`ifndef DHP_MAP_SVH
`define DHP_MAP_SVH
`define DHP_ADDR_HOLD 3'h0
`define DHP_ADDR_PCR 3'h4
`define DHP_ADDR_LINE 3'h5
`define DHP_PCR_OUT2_BIT 3
`define DHP_LINE_RXDATA_BIT 0
`define DHP_LINE_THR_EMPTY_BIT 5
`define DHP_LINE_TX_EMPTY_BIT 6
`define DHP_BYTE_RESET 8'h00
`define DHP_PCR_RESET 8'h00
`endif

// *** dhp_pkg.sv ***
// Types shared by the host port and its channel register blocks.
package dhp_pkg;
	typedef logic [7:0] dhp_byte_type;
	typedef logic [2:0] dhp_addr_type;
	typedef enum logic [2:0] {
		DHP_IDLE = 3'h1,
		DHP_READ = 3'h2,
		DHP_WRITE = 3'h4
	} dhp_bus_state_type;
endpackage : dhp_pkg

// *** dhp_top.sv ***
// Parallel host port of a dual-channel serial controller, with per-channel pins.
// Summary of operation
// - Three address lines pick the channel register.
// - Eight-bit data bus, driven only on reads.
// - Read strobe fall fetches byte onto bus.
// - Write strobe rise stores the bus byte.
// - Channel A acts only while its select low.
// - Channel B acts only while its select low.
// - Channel A control bit one: interrupt driven, user low.
// - Channel A control bit zero: interrupt released, user high.
// - Channel B interrupt and user output follow its bit.
// - Channel A transmit ready, active low, from holding.
// - Channel A receive ready, active low, from holding.
// - Channel B transmit ready, active low, from holding.
// - Channel B receive ready, active low, from holding.
`timescale 1ns/1ps
`include "dhp_map.svh"
module dhp_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Host bus
	input wire dhp_pkg::dhp_addr_type addr,
	input wire dhp_pkg::dhp_byte_type data_in,
	output dhp_pkg::dhp_byte_type data_out,
	output logic data_oe,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic chan_a_select_n,
	input wire logic chan_b_select_n,
	// Channel A pins
	output logic chan_a_irq,
	output logic chan_a_irq_oe,
	output logic chan_a_user_output_n,
	output logic chan_a_tx_ready_n,
	output logic chan_a_rx_ready_n,
	// Channel B pins
	output logic chan_b_irq,
	output logic chan_b_irq_oe,
	output logic chan_b_user_output_n,
	output logic chan_b_tx_ready_n,
	output logic chan_b_rx_ready_n,
	// Channel A serial side
	output dhp_pkg::dhp_byte_type chan_a_tx_data,
	output logic chan_a_tx_valid,
	input wire logic chan_a_tx_take,
	input wire dhp_pkg::dhp_byte_type chan_a_rx_data,
	input wire logic chan_a_rx_push,
	input wire logic chan_a_irq_req,
	// Channel B serial side
	output dhp_pkg::dhp_byte_type chan_b_tx_data,
	output logic chan_b_tx_valid,
	input wire logic chan_b_tx_take,
	input wire dhp_pkg::dhp_byte_type chan_b_rx_data,
	input wire logic chan_b_rx_push,
	input wire logic chan_b_irq_req
);
	import dhp_pkg::*;

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_q, rst_n_q;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ****************************************
	// Strobe framing
	// ****************************************
	dhp_bus_state_type state_q, state_d;
	dhp_addr_type addr_q, addr_d;
	dhp_byte_type wdata_q, wdata_d, data_out_q, data_out_d;
	logic sel_b_q, sel_b_d, rd_pulse_q, rd_pulse_d, wr_pulse_q, wr_pulse_d, data_oe_q, data_oe_d;
	logic sel_a_in, sel_b_in, sel_one;
	dhp_byte_type rdata_a, rdata_b;

	always_comb begin
		sel_a_in = !chan_a_select_n;
		sel_b_in = !chan_b_select_n;
		// A cycle selecting both channels is ignored outright rather than writing two channels.
		sel_one = sel_a_in ^ sel_b_in;
		state_d = state_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		sel_b_d = sel_b_q;
		rd_pulse_d = 1'b0;
		wr_pulse_d = 1'b0;
		data_out_d = data_out_q;
		case (state_q)
			DHP_IDLE: begin
				if (sel_one && !read_strobe_n && write_strobe_n) begin
					state_d = DHP_READ;
					rd_pulse_d = 1'b1;
					addr_d = addr;
					sel_b_d = sel_b_in;
				end else if (sel_one && !write_strobe_n && read_strobe_n) begin
					state_d = DHP_WRITE;
					addr_d = addr;
					wdata_d = data_in;
					sel_b_d = sel_b_in;
				end
			end
			DHP_READ: begin
				data_out_d = sel_b_q ? rdata_b : rdata_a;
				if (read_strobe_n) begin
					state_d = DHP_IDLE;
				end
			end
			DHP_WRITE: begin
				if (write_strobe_n) begin
					// The byte and address held in the last low cycle are stored at the rising edge.
					state_d = DHP_IDLE;
					wr_pulse_d = 1'b1;
				end else begin
					addr_d = addr;
					wdata_d = data_in;
				end
			end
			default: state_d = DHP_IDLE;
		endcase
		// The bus is driven only while a selected read strobe stays low.
		data_oe_d = (state_d == DHP_READ) && ((sel_b_q ? sel_b_in : sel_a_in) || state_q == DHP_IDLE);
	end

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= DHP_IDLE;
			addr_q <= `DHP_ADDR_HOLD;
			wdata_q <= `DHP_BYTE_RESET;
			sel_b_q <= 1'b0;
			rd_pulse_q <= 1'b0;
			wr_pulse_q <= 1'b0;
			data_out_q <= `DHP_BYTE_RESET;
			data_oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			sel_b_q <= sel_b_d;
			rd_pulse_q <= rd_pulse_d;
			wr_pulse_q <= wr_pulse_d;
			data_out_q <= data_out_d;
			data_oe_q <= data_oe_d;
		end
	end

	assign data_out = data_out_q;
	assign data_oe = data_oe_q;

	// ****************************************
	// Channels
	// ****************************************
	dhp_chan u_chan_a (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.rd_pulse(rd_pulse_q && !sel_b_q),
		.wr_pulse(wr_pulse_q && !sel_b_q),
		.addr(addr_q),
		.wdata(wdata_q),
		.rdata(rdata_a),
		.tx_data(chan_a_tx_data),
		.tx_valid(chan_a_tx_valid),
		.tx_take(chan_a_tx_take),
		.rx_data(chan_a_rx_data),
		.rx_push(chan_a_rx_push),
		.irq_req(chan_a_irq_req),
		.irq_out(chan_a_irq),
		.irq_oe(chan_a_irq_oe),
		.user_output_n(chan_a_user_output_n),
		.tx_ready_n(chan_a_tx_ready_n),
		.rx_ready_n(chan_a_rx_ready_n)
	);

	dhp_chan u_chan_b (
		.clk(ref_clk),
		.rst_n(rst_n_q),
		.rd_pulse(rd_pulse_q && sel_b_q),
		.wr_pulse(wr_pulse_q && sel_b_q),
		.addr(addr_q),
		.wdata(wdata_q),
		.rdata(rdata_b),
		.tx_data(chan_b_tx_data),
		.tx_valid(chan_b_tx_valid),
		.tx_take(chan_b_tx_take),
		.rx_data(chan_b_rx_data),
		.rx_push(chan_b_rx_push),
		.irq_req(chan_b_irq_req),
		.irq_out(chan_b_irq),
		.irq_oe(chan_b_irq_oe),
		.user_output_n(chan_b_user_output_n),
		.tx_ready_n(chan_b_tx_ready_n),
		.rx_ready_n(chan_b_rx_ready_n)
	);

	// ****************************************
	// Assertions
	// ****************************************
	AST_ADDR_TAKEN: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		rd_pulse_q |-> addr_q == $past(addr))
		else $error("Read address not taken from the address lines.");
	AST_OE_READ_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		data_oe_q |-> $past(!read_strobe_n) && $past(write_strobe_n || state_q == DHP_READ))
		else $error("Data bus driven outside a read.");
	AST_NO_OE_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		state_q == DHP_WRITE |-> !data_oe_q)
		else $error("Data bus driven during a write.");
	AST_READ_DATA: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		rd_pulse_q ##1 state_q == DHP_READ |=> data_out_q == $past(sel_b_q ? rdata_b : rdata_a))
		else $error("Read byte not placed on the bus two cycles after the strobe fall.");
	AST_WRITE_RISE: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		$past(state_q == DHP_WRITE) && $rose(write_strobe_n) |=> wr_pulse_q && wdata_q == $past(data_in, 2)
		&& addr_q == $past(addr, 2))
		else $error("Write not issued at the strobe rising edge.");
	AST_SEL_A: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		rd_pulse_q && !sel_b_q |-> $past(!chan_a_select_n && chan_b_select_n))
		else $error("Channel A accessed without its select.");
	AST_SEL_B: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		rd_pulse_q && sel_b_q |-> $past(!chan_b_select_n && chan_a_select_n))
		else $error("Channel B accessed without its select.");
	// A read may legally start in the idle cycle that issues a write, so each pulse is checked on its own.
	AST_PULSE_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
		(rd_pulse_q |=> !rd_pulse_q) and (wr_pulse_q |=> !wr_pulse_q))
		else $error("Access pulse longer than one cycle.");
	COV_READ_A: cover property (@(posedge ref_clk) disable iff (!rst_n_q) rd_pulse_q && !sel_b_q);
	COV_WRITE_B: cover property (@(posedge ref_clk) disable iff (!rst_n_q) wr_pulse_q && sel_b_q);
	COV_BOTH_SEL: cover property (@(posedge ref_clk) disable iff (!rst_n_q)
		!chan_a_select_n && !chan_b_select_n && !read_strobe_n);
endmodule : dhp_top

// *** dual_uart_host_bus_port_tb_top.sv ***
// Self-checking bench of the dual-channel host port.
`timescale 1ns/1ps
module dual_uart_host_bus_port_tb_top;
	import dhp_pkg::*;
	typedef struct packed {logic chan; dhp_addr_type a; dhp_byte_type w; dhp_byte_type r;} dhp_row_type;
	logic ref_clk, resetn, data_oe, rd_n, wr_n, sel_a_n, sel_b_n, ok;
	dhp_addr_type addr;
	dhp_byte_type data_in, data_out, rd_val;
	logic [1:0] irq, irq_oe, user_n, txr_n, rxr_n, tx_valid, tx_take, rx_push, irq_req;
	dhp_byte_type tx_data [2];
	dhp_byte_type rx_data [2];
	int fail_count = 0;
	int check_count = 0;
	// Control writes on A come before B so the other channel's enable is known to be clear.
	dhp_row_type rows [8] = '{'{1'h0, 3'h4, 8'h08, 8'h08}, '{1'h0, 3'h4, 8'h00, 8'h00},
		'{1'h1, 3'h4, 8'h08, 8'h08}, '{1'h1, 3'h4, 8'h00, 8'h00}, '{1'h0, 3'h1, 8'hA5, 8'hA5},
		'{1'h1, 3'h1, 8'h3C, 8'h3C}, '{1'h0, 3'h5, 8'hFF, 8'h60}, '{1'h1, 3'h7, 8'h5A, 8'h5A}};
	dhp_host_model i_host (.ref_clk(ref_clk), .addr(addr), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chan_a_select_n(sel_a_n),
		.chan_b_select_n(sel_b_n));
	dhp_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chan_a_select_n(sel_a_n),
		.chan_b_select_n(sel_b_n), .chan_a_irq(irq[0]), .chan_a_irq_oe(irq_oe[0]),
		.chan_a_user_output_n(user_n[0]), .chan_a_tx_ready_n(txr_n[0]), .chan_a_rx_ready_n(rxr_n[0]),
		.chan_b_irq(irq[1]), .chan_b_irq_oe(irq_oe[1]), .chan_b_user_output_n(user_n[1]),
		.chan_b_tx_ready_n(txr_n[1]), .chan_b_rx_ready_n(rxr_n[1]), .chan_a_tx_data(tx_data[0]),
		.chan_a_tx_valid(tx_valid[0]), .chan_a_tx_take(tx_take[0]), .chan_a_rx_data(rx_data[0]),
		.chan_a_rx_push(rx_push[0]), .chan_a_irq_req(irq_req[0]), .chan_b_tx_data(tx_data[1]),
		.chan_b_tx_valid(tx_valid[1]), .chan_b_tx_take(tx_take[1]), .chan_b_rx_data(rx_data[1]),
		.chan_b_rx_push(rx_push[1]), .chan_b_irq_req(irq_req[1]));
	// ****************************************
	// Checking and reporting
	// ****************************************
	task automatic check_byte(input dhp_byte_type act, input dhp_byte_type exp);
		check_count++;
		if (act !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, act, exp);
		end
	endtask : check_byte
	task automatic check_bit(input logic act, input logic exp);
		check_count++;
		if (act !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, act, exp);
		end
	endtask : check_bit
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		#400000;
		fail_count++;
		print_verdict();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		resetn = 1'b0;
		tx_take = 2'h0;
		rx_push = 2'h0;
		irq_req = 2'h0;
		rx_data = '{8'h00, 8'h00};
		repeat (3) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (4) @(negedge ref_clk);
		for (int c = 0; c < 2; c++) begin
			check_bit(irq_oe[c], 1'b0);
			check_bit(user_n[c], 1'b1);
			check_bit(txr_n[c], 1'b0);
			check_bit(rxr_n[c], 1'b1);
		end
		check_bit(data_oe, 1'b0);
		foreach (rows[i]) begin
			i_host.bus_write(rows[i].chan, 1'b0, rows[i].a, rows[i].w);
			i_host.bus_read(rows[i].chan, rows[i].a, rd_val, ok);
			check_byte(rd_val, rows[i].r);
			check_bit(ok, 1'b1);
			if (rows[i].a == 3'h4) begin
				check_bit(irq_oe[rows[i].chan], rows[i].w[3]);
				check_bit(user_n[rows[i].chan], ~rows[i].w[3]);
				check_bit(irq_oe[~rows[i].chan], 1'b0);
			end
		end
		// Each channel in turn: fill and drain the transmit holding, then receive and pop a byte.
		for (int c = 0; c < 2; c++) begin
			i_host.bus_write(c[0], 1'b0, 3'h0, 8'h3C ^ {8{c[0]}});
			check_bit(txr_n[c], 1'b1);
			check_bit(tx_valid[c], 1'b1);
			check_byte(tx_data[c], 8'h3C ^ {8{c[0]}});
			check_bit(txr_n[1 - c], 1'b0);
			tx_take[c] = 1'b1;
			@(negedge ref_clk);
			tx_take[c] = 1'b0;
			repeat (2) @(negedge ref_clk);
			check_bit(txr_n[c], 1'b0);
			check_bit(tx_valid[c], 1'b0);
			rx_data[c] = 8'h96 ^ {8{c[0]}};
			rx_push[c] = 1'b1;
			@(negedge ref_clk);
			rx_push[c] = 1'b0;
			repeat (2) @(negedge ref_clk);
			check_bit(rxr_n[c], 1'b0);
			check_bit(rxr_n[1 - c], 1'b1);
			i_host.bus_read(c[0], 3'h5, rd_val, ok);
			check_byte(rd_val, 8'h61);
			i_host.bus_read(c[0], 3'h0, rd_val, ok);
			check_byte(rd_val, 8'h96 ^ {8{c[0]}});
			check_bit(rxr_n[c], 1'b1);
		end
		// Both selects low must leave every register untouched.
		i_host.bus_write(1'b0, 1'b1, 3'h1, 8'hFF);
		i_host.bus_read(1'b0, 3'h1, rd_val, ok);
		check_byte(rd_val, 8'hA5);
		i_host.bus_read(1'b1, 3'h1, rd_val, ok);
		check_byte(rd_val, 8'h3C);
		i_host.bus_write(1'b0, 1'b0, 3'h4, 8'h08);
		irq_req = 2'h3;
		repeat (3) @(negedge ref_clk);
		check_bit(irq[0], 1'b1);
		check_bit(irq_oe[1], 1'b0);
		check_bit(irq[1], 1'b1);
		irq_req = 2'h0;
		repeat (3) @(negedge ref_clk);
		check_bit(irq[0], 1'b0);
		check_bit(irq[1], 1'b0);
		resetn = 1'b0;
		repeat (3) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (4) @(negedge ref_clk);
		check_bit(irq_oe[0], 1'b0);
		check_bit(user_n[0], 1'b1);
		check_bit(txr_n[0], 1'b0);
		i_host.bus_read(1'b0, 3'h1, rd_val, ok);
		check_byte(rd_val, 8'h00);
		check_bit(ok, 1'b1);
		print_verdict();
	end
endmodule : dual_uart_host_bus_port_tb_top
